// file: bench/halt_standby_clock_control_tb_top.sv
// Self-checking bench of the halt and standby clock controller.
// Assumes the far-side model for the pins; the bench plays the core.
`timescale 1ns/10ps
`include "hsc_cfg.svh"
module halt_standby_clock_control_tb_top;
    import hsc_pkg::*;
    localparam int WARM = 8;
    logic       clk_i, resetn_i = 1'b0, fetch_cycle = 1'b1, halt_decode = 1'b0;
    logic       int_enable = 1'b0, rst_req = 1'b0, int_req = 1'b0, nmi_req = 1'b0;
    logic       halt_n, phi, phi_tick, clk_out, osc_run, core_reset, fetch_zero;
    logic       int_ack, nmi_ack, fetch_n, ref_en;
    logic [1:0] tstate;
    logic [6:0] ref_addr;
    hsc_pin_s   pins;
    hsc_mode_e  mode = HSC_MODE_RUN;
    int         fail_count = 0;
    int         tests_run = 0;

    hsc_far_side u_far (.clk_i(clk_i), .rst_req_i(rst_req), .int_req_i(int_req),
        .nmi_req_i(nmi_req), .mode_i(mode), .pins_o(pins));
    hsc_top #(.WARMUP_CYC(WARM)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins),
        .fetch_cycle_i(fetch_cycle), .halt_decode_i(halt_decode), .int_enable_i(int_enable),
        .nmi_taken_i(1'b0), .halt_n_o(halt_n), .phi_o(phi), .phi_tick_o(phi_tick),
        .tstate_o(tstate), .clk_out_o(clk_out), .osc_run_o(osc_run),
        .core_reset_o(core_reset), .fetch_zero_o(fetch_zero), .int_ack_o(int_ack),
        .nmi_ack_o(nmi_ack), .opcode_fetch_cycle_n_o(fetch_n),
        .refresh_addr_en_o(ref_en), .refresh_addr_o(ref_addr));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // Counts cycles until the core clock changes, giving up after lim cycles.
    task automatic phi_wait(input int lim, output int n);
        logic p;
        p = phi;
        for (n = 0; n < lim && phi === p; n++) step();
    endtask : phi_wait

    task automatic do_halt(input hsc_mode_e m);
        int n;
        mode = m;
        step(8);
        halt_decode = 1'b1;
        for (n = 0; n < 40 && halt_n !== 1'b0; n++) step();
        halt_decode = 1'b0;
        check("halt_n", 16'h0, {15'h0, halt_n});
        step(6);
    endtask : do_halt

    task automatic t_reset;
        int n;
        for (n = 0; n < 40 && fetch_zero !== 1'b1; n++) step();
        check("fetch_zero", 16'h1, {15'h0, fetch_zero});
        step();
        check("core_reset", 16'h0, {15'h0, core_reset});
        $display("test reset done");
    endtask : t_reset

    task automatic t_run;
        int n;
        logic [6:0] a;
        logic c;
        a = ref_addr;
        step(10);
        check("refresh_moves", 16'h1, {15'h0, ref_addr !== a});
        do_halt(HSC_MODE_RUN);
        c = clk_out;
        phi_wait(3, n);
        check("run_phi", 16'h1, {15'h0, n < 3});
        check("run_clk_out", 16'h1, {15'h0, clk_out !== c});
        int_req = 1'b1;
        step(24);
        check("int_refused", 16'h0, {15'h0, halt_n});
        int_enable = 1'b1;
        for (n = 0; n < 20 && int_ack !== 1'b1; n++) step();
        check("int_ack", 16'h1, {15'h0, int_ack});
        int_req = 1'b0;
        int_enable = 1'b0;
        step(2);
        check("halt_release", 16'h1, {15'h0, halt_n});
        $display("test run mode done");
    endtask : t_run

    task automatic t_idle(input hsc_mode_e m);
        int n;
        logic c;
        do_halt(m);
        c = clk_out;
        step();
        check("gate_phi", 16'h0, {15'h0, phi});
        check("gate_tstate", 16'h3, {14'h0, tstate});
        check("gate_clk_out", {15'h0, m != HSC_MODE_GATED_ALL}, {15'h0, clk_out !== c});
        check("gate_osc", 16'h1, {15'h0, osc_run});
        c = clk_out;
        int_req = 1'b1;
        phi_wait(20, n);
        check("wake_phi", 16'h1, {15'h0, n < 20});
        if (m == HSC_MODE_GATED_ALL) begin
            check("wake_clk_out", 16'h1, {15'h0, clk_out !== c});
        end
        int_req = 1'b0;
        step(24);
        check("regate_phi", 16'h0, {15'h0, phi});
        check("regate_halt", 16'h0, {15'h0, halt_n});
        nmi_req = 1'b1;
        for (n = 0; n < 40 && nmi_ack !== 1'b1; n++) step();
        check("nmi_ack", 16'h1, {15'h0, nmi_ack});
        nmi_req = 1'b0;
        step(4);
        $display("test standby mode %0d done", m);
    endtask : t_idle

    task automatic t_stop;
        int n;
        do_halt(HSC_MODE_STOP);
        check("stop_osc", 16'h0, {15'h0, osc_run});
        check("stop_clk_out", 16'h0, {15'h0, clk_out});
        // A second wake shows the warm-up count starts afresh.
        repeat (2) begin
            int_req = 1'b1;
            int_enable = 1'b1;
            for (n = 0; n < 20 && osc_run !== 1'b1; n++) step();
            phi_wait(WARM + 20, n);
            check("warmup", 16'h1, {15'h0, n >= WARM});
            for (n = 0; n < 20 && int_ack !== 1'b1; n++) step();
            check("stop_int_ack", 16'h1, {15'h0, int_ack});
            int_req = 1'b0;
            int_enable = 1'b0;
            phi_wait(3, n);
            check("run_any_mode", 16'h1, {15'h0, n < 3});
            do_halt(HSC_MODE_STOP);
        end
        rst_req = 1'b1;
        step();
        rst_req = 1'b0;
        for (n = 0; n < 20 && osc_run !== 1'b1; n++) step();
        phi_wait(4, n);
        check("reset_no_warm", 16'h1, {15'h0, n < 4});
        for (n = 0; n < 60 && fetch_zero !== 1'b1; n++) step();
        check("reset_fetch_zero", 16'h1, {15'h0, fetch_zero});
        check("reset_halt_n", 16'h1, {15'h0, halt_n});
        $display("test stop mode done");
    endtask : t_stop

    task automatic complete_run;
        $display("counts: tests_run %0d fail_count %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    // The whole sequence needs under a thousand cycles; ten thousand leaves margin.
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    initial begin
        step(20);
        resetn_i = 1'b1;
        t_reset();
        t_run();
        t_idle(HSC_MODE_GATED_ALL);
        t_idle(HSC_MODE_GATED_CORE);
        t_stop();
        complete_run();
    end
endmodule : halt_standby_clock_control_tb_top

// file: bench/hsc_far_side.sv
// Far-side model: reset source, interrupt sources and standby strapping on the pins.
// Assumes bench commands that change just after the rising clock edge.
`timescale 1ns/10ps
module hsc_far_side #(
    parameter int RST_MIN = 10
) (
    input  wire logic               clk_i,
    input  wire logic               rst_req_i,
    input  wire logic               int_req_i,
    input  wire logic               nmi_req_i,
    input  wire hsc_pkg::hsc_mode_e mode_i,
    output hsc_pkg::hsc_pin_s       pins_o
);
    import hsc_pkg::*;
    int hold_cnt = 0;
    initial pins_o = 5'h1F;
    // Pins move a little after the edge, as a real source is not aligned to the core clock.
    always @(posedge clk_i) begin
        #2;
        if (rst_req_i) begin
            hold_cnt = RST_MIN;
        end else if (hold_cnt > 0) begin
            hold_cnt = hold_cnt - 1;
        end
        pins_o.ext_reset_n = (hold_cnt == 0);
        pins_o.int_req_n = ~int_req_i;
        pins_o.nmi_req_n = ~nmi_req_i;
        {pins_o.standby_select_a, pins_o.standby_select_b} = mode_i;
    end
endmodule : hsc_far_side

// file: bench/hsc_top_assertions.sv
// Concurrent checks on the ports of the halt and standby clock controller.
// Assumes one clock domain, clk_i, with resetn_i as its synchronous active-low reset.
`timescale 1ns/10ps
`include "hsc_cfg.svh"
module hsc_top_assertions #(
    parameter int WARMUP_CYC = 8
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire hsc_pkg::hsc_pin_s pins_i,
    input  wire logic              fetch_cycle_i,
    input  wire logic              halt_decode_i,
    input  wire logic              int_enable_i,
    input  wire logic              halt_n_o,
    input  wire logic              phi_o,
    input  wire logic              phi_tick_o,
    input  wire logic [1:0]        tstate_o,
    input  wire logic              clk_out_o,
    input  wire logic              osc_run_o,
    input  wire logic              core_reset_o,
    input  wire logic              fetch_zero_o,
    input  wire logic              int_ack_o,
    input  wire logic              nmi_ack_o,
    input  wire logic              opcode_fetch_cycle_n_o,
    input  wire logic              refresh_addr_en_o
);
    import hsc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    int warm_ff;

    sequence s_halt_take;
        fetch_cycle_i && halt_decode_i && halt_n_o && !core_reset_o
            && tstate_o == `HSC_T4 && !phi_tick_o && phi_o;
    endsequence
    sequence s_frozen;
        (!halt_n_o && phi_o == $past(phi_o) && tstate_o == $past(tstate_o))[*2];
    endsequence

    // Cycles since the oscillator restarted; saturates at the limit.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            warm_ff <= WARMUP_CYC;
        end else if ($rose(osc_run_o)) begin
            warm_ff <= 0;
        end else if (warm_ff < WARMUP_CYC) begin
            warm_ff <= warm_ff + 1;
        end
    end

    chk_halt_entry: assert property (s_halt_take |=> !halt_n_o)
        else $error("halt output stayed high after a halt fetch");
    chk_run_clock: assert property (halt_n_o[*4] |-> phi_o != $past(phi_o))
        else $error("core clock stopped while not halted");
    chk_idle_freeze: assert property (s_frozen |-> !phi_o && tstate_o == `HSC_T4)
        else $error("core clock frozen outside T4 low");
    chk_gated_all: assert property (s_frozen ##0 (pins_i.standby_select_a == 1'b0
        && pins_i.standby_select_b == 1'b0) |-> !clk_out_o)
        else $error("clock output running in gated-all standby");
    chk_gated_core: assert property (s_frozen ##0 (pins_i.standby_select_a == 1'b0
        && pins_i.standby_select_b == 1'b1) |-> clk_out_o != $past(clk_out_o))
        else $error("clock output stopped in gated-core standby");
    chk_stop_osc: assert property ($fell(osc_run_o) |-> !halt_n_o && !phi_o)
        else $error("oscillator stopped outside a halt");
    chk_warm_hold: assert property (warm_ff < WARMUP_CYC - 2 && !halt_n_o
        && !core_reset_o |-> phi_o == $past(phi_o) && !clk_out_o)
        else $error("clocks restarted before warm-up ended");
    chk_int_enable: assert property (int_ack_o |-> $past(int_enable_i) && !$past(halt_n_o))
        else $error("maskable request accepted while disabled or not halted");
    chk_ack_release: assert property (int_ack_o || nmi_ack_o |-> ##[0:1] halt_n_o)
        else $error("halt not released after acceptance");
    chk_dummy_len: assert property ($fell(core_reset_o) |-> $past(pins_i.ext_reset_n, 9))
        else $error("dummy cycle shorter than two T-states");
    chk_fetch_zero: assert property ($fell(core_reset_o) |-> ##[0:1] fetch_zero_o)
        else $error("no fetch from zero after reset");
    chk_refresh_slot: assert property (refresh_addr_en_o
        |-> tstate_o >= `HSC_T3 && opcode_fetch_cycle_n_o)
        else $error("refresh address outside T3 and T4 of a fetch");
endmodule : hsc_top_assertions

bind hsc_top hsc_top_assertions #(.WARMUP_CYC(WARMUP_CYC)) u_chk (
    .clk_i(clk_i), .resetn_i(resetn_i), .pins_i(pins_i), .fetch_cycle_i(fetch_cycle_i),
    .halt_decode_i(halt_decode_i), .int_enable_i(int_enable_i), .halt_n_o(halt_n_o),
    .phi_o(phi_o), .phi_tick_o(phi_tick_o), .tstate_o(tstate_o), .clk_out_o(clk_out_o),
    .osc_run_o(osc_run_o), .core_reset_o(core_reset_o), .fetch_zero_o(fetch_zero_o),
    .int_ack_o(int_ack_o), .nmi_ack_o(nmi_ack_o),
    .opcode_fetch_cycle_n_o(opcode_fetch_cycle_n_o), .refresh_addr_en_o(refresh_addr_en_o));

// file: hdl/hsc_cfg.svh
// Constants of the halt and standby clock controller: timing, encodings, reset values.
// Assumes the including file is compiled after the package that holds the types.
`ifndef HSC_CFG_SVH
`define HSC_CFG_SVH

// Period of clk_i in nanoseconds (100 MHz).
`define HSC_CLK_PERIOD_NS  10
// Period of the generated clock output in nanoseconds.
`define HSC_TCC_NS         20
// clk_i cycles in one half period of the generated clock.
`define HSC_HALF_CYC       (`HSC_TCC_NS / 2 / `HSC_CLK_PERIOD_NS)
`define HSC_HALF_W         4
// Stop-mode warm-up: (2^14 + 2.5) clock periods, kept doubled as whole half periods.
`define HSC_WARM_TCC_X2    (2 * 16384 + 5)
`define HSC_WARM_CYC       (`HSC_WARM_TCC_X2 * `HSC_HALF_CYC)
`define HSC_WARM_W         16
`define HSC_WARM_RST       16'h0000
// T-states of the dummy cycle that follows a reset release.
`define HSC_DUMMY_T        2
`define HSC_DUMMY_W        2
`define HSC_DUMMY_RST      2'h0
// T-state encodings within a machine cycle.
`define HSC_T1             2'h0
`define HSC_T3             2'h2
`define HSC_T4             2'h3
`define HSC_T_STEP         2'h1
// Refresh address counter.
`define HSC_REF_W          7
`define HSC_REF_RST        7'h00
`define HSC_REF_STEP       7'h01
// Synchroniser reset value: all pins idle high, which selects run mode.
`define HSC_PIN_RST        5'h1F

`endif

// file: hdl/hsc_pkg.sv
// Types shared by the halt and standby clock controller.
// Assumes nothing of its surroundings.
package hsc_pkg;

    // Standby selection, packed as {standby_select_a, standby_select_b}.
    typedef enum logic [1:0] {
        HSC_MODE_GATED_ALL  = 2'b00,
        HSC_MODE_GATED_CORE = 2'b01,
        HSC_MODE_STOP       = 2'b10,
        HSC_MODE_RUN        = 2'b11
    } hsc_mode_e;

    // Gray codes along reset, dummy, run, halt, gate, stop, warm-up.
    typedef enum logic [2:0] {
        HSC_ST_RST_HOLD = 3'b000,
        HSC_ST_DUMMY    = 3'b001,
        HSC_ST_RUN      = 3'b011,
        HSC_ST_HALT_NOP = 3'b010,
        HSC_ST_GATED    = 3'b110,
        HSC_ST_STOPPED  = 3'b111,
        HSC_ST_WARMUP   = 3'b101
    } hsc_state_e;

    // Asynchronous pins of the device, all active low except the selects.
    typedef struct packed {
        logic ext_reset_n;
        logic int_req_n;
        logic nmi_req_n;
        logic standby_select_a;
        logic standby_select_b;
    } hsc_pin_s;

endpackage : hsc_pkg

// file: hdl/hsc_top.sv
// Halt and standby clock controller: clock gating, oscillator control, wake-up and reset.
// Assumes a core on clk_i that reports fetch cycles and a decoded halt opcode, and
// asynchronous pins that are synchronised here.
`timescale 1ns/10ps
`include "hsc_cfg.svh"

// Three-stage synchroniser; a change counts once the second and third stages agree.
module hsc_sync3 #(
    parameter int         W   = 1,
    parameter logic [W-1:0] RST = '0
) (
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s1_ff <= RST;
            s2_ff <= RST;
            s3_ff <= RST;
        end else begin
            s1_ff <= d_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // Each bit follows only when the later two stages agree, so a single skewed sample never counts.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q_ff <= RST;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_ff[i] == s3_ff[i]) begin
                    q_ff[i] <= s3_ff[i];
                end
            end
        end
    end

    assign q_o = q_ff;
endmodule : hsc_sync3

// Summary of operation
// - Halt fetch drives halt low at T4 fall
// - Halted with clock running, keep executing NOPs
// - Run mode keeps both clocks running
// - First idle stops core and output clocks
// - Second idle stops core clock only
// - Stop mode stops oscillator and both clocks
// - Idle modes freeze clock at T4 low
// - Halted: sample requests at T4 rise
// - Maskable accepted only when low and enabled
// - Non-maskable edge sets latch; accept when set
// - Accepted interrupt starts response next cycle
// - Reset or request restarts gated core clock
// - First idle wake restarts output clock together
// - After idle wake run one NOP, regate
// - Stop wake: oscillator on, count warm-up first
// - After warm-up run NOP, sample at T4
// - Reset wake from stop skips warm-up
// - After reset: two-T dummy, fetch from zero
// - Reset in idle restarts clock, resumes zero
// - Fetch cycles drive refresh address onto bus
// - Not halted: clock supplied whatever the mode
module hsc_top #(
    parameter int WARMUP_CYC = `HSC_WARM_CYC
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire hsc_pkg::hsc_pin_s pins_i,
    input  wire logic              fetch_cycle_i,
    input  wire logic              halt_decode_i,
    input  wire logic              int_enable_i,
    input  wire logic              nmi_taken_i,
    output logic                   halt_n_o,
    output logic                   phi_o,
    output logic                   phi_tick_o,
    output logic [1:0]             tstate_o,
    output logic                   clk_out_o,
    output logic                   osc_run_o,
    output logic                   core_reset_o,
    output logic                   fetch_zero_o,
    output logic                   int_ack_o,
    output logic                   nmi_ack_o,
    output logic                   opcode_fetch_cycle_n_o,
    output logic                   refresh_addr_en_o,
    output logic [`HSC_REF_W-1:0]  refresh_addr_o
);
    import hsc_pkg::*;

    localparam logic [`HSC_HALF_W-1:0]  HALF_LAST  = `HSC_HALF_W'(`HSC_HALF_CYC - 1);
    localparam logic [`HSC_WARM_W-1:0]  WARM_LAST  = `HSC_WARM_W'(WARMUP_CYC - 1);
    localparam logic [`HSC_DUMMY_W-1:0] DUMMY_LAST = `HSC_DUMMY_W'(`HSC_DUMMY_T - 1);

    hsc_pin_s                 pin_s;
    hsc_state_e               state_ff;
    hsc_state_e               nxt_state;
    hsc_mode_e                mode;
    hsc_mode_e                gate_mode_ff;
    logic [`HSC_HALF_W-1:0]   half_cnt_ff;
    logic                     phase_ff;
    logic [1:0]               tstate_ff;
    logic [`HSC_WARM_W-1:0]   warm_ff;
    logic [`HSC_DUMMY_W-1:0]  dummy_ff;
    logic [`HSC_REF_W-1:0]    ref_ff;
    logic                     nmi_prev_ff;
    logic                     nmi_lat_ff;
    logic                     halt_n_ff;
    logic                     phi_ff;
    logic                     clk_out_ff;
    logic                     osc_run_ff;
    logic                     fetch_zero_ff;
    logic                     int_ack_ff;
    logic                     nmi_ack_ff;
    logic                     rst_pin;
    logic                     int_req;
    logic                     nmi_fall;
    logic                     osc_on;
    logic                     run_clk;
    logic                     free_tick;
    logic                     half_tick;
    logic                     t_end;
    logic                     t4_begin;
    logic                     t4_fall;
    logic                     fetch_now;
    logic                     halt_fetch;
    logic                     nmi_acc;
    logic                     int_acc;
    logic                     wake_req;

    hsc_sync3 #(
        .W   ($bits(hsc_pin_s)),
        .RST (`HSC_PIN_RST)
    ) u_sync (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .d_i      (pins_i),
        .q_o      (pin_s)
    );

    assign mode     = hsc_mode_e'({pin_s.standby_select_a, pin_s.standby_select_b});
    assign rst_pin  = !pin_s.ext_reset_n;
    assign int_req  = !pin_s.int_req_n;
    assign nmi_fall = nmi_prev_ff && !pin_s.nmi_req_n;

    // The oscillator runs in every state but stop and stays on through the warm-up.
    assign osc_on  = (state_ff != HSC_ST_STOPPED);
    // Core clock runs outside the gated, stopped and warm-up states, whatever the selects say.
    assign run_clk = (state_ff == HSC_ST_RST_HOLD) || (state_ff == HSC_ST_DUMMY) ||
                     (state_ff == HSC_ST_RUN) || (state_ff == HSC_ST_HALT_NOP);

    assign free_tick = osc_on && (half_cnt_ff == HALF_LAST);
    assign half_tick = free_tick && run_clk;
    assign t_end     = half_tick && phase_ff;
    assign t4_begin  = t_end && (tstate_ff == `HSC_T3);
    assign t4_fall   = half_tick && !phase_ff && (tstate_ff == `HSC_T4);

    // Halt NOPs are opcode fetches too, so they carry refresh addresses as well.
    assign fetch_now  = (state_ff == HSC_ST_HALT_NOP) ||
                        ((state_ff == HSC_ST_RUN) && fetch_cycle_i);
    assign halt_fetch = (state_ff == HSC_ST_RUN) && fetch_cycle_i && halt_decode_i;

    // A pending non-maskable request takes precedence over a maskable one.
    assign nmi_acc = (state_ff == HSC_ST_HALT_NOP) && t4_begin && nmi_lat_ff;
    assign int_acc = (state_ff == HSC_ST_HALT_NOP) && t4_begin && !nmi_lat_ff &&
                     int_req && int_enable_i;
    // A maskable request level or a latched non-maskable edge wakes the clock; enable is judged only at the sampling point.
    assign wake_req = int_req || nmi_lat_ff;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            HSC_ST_RST_HOLD: begin
                if (!rst_pin && t_end) begin
                    nxt_state = HSC_ST_DUMMY;
                end
            end
            HSC_ST_DUMMY: begin
                if (t_end && (dummy_ff == DUMMY_LAST)) begin
                    nxt_state = HSC_ST_RUN;
                end
            end
            HSC_ST_RUN: begin
                if (t4_fall && halt_fetch) begin
                    case (mode)
                        HSC_MODE_RUN:  nxt_state = HSC_ST_HALT_NOP;
                        HSC_MODE_STOP: nxt_state = HSC_ST_STOPPED;
                        default:       nxt_state = HSC_ST_GATED;
                    endcase
                end
            end
            HSC_ST_HALT_NOP: begin
                if (nmi_acc || int_acc) begin
                    nxt_state = HSC_ST_RUN;
                end else if (t4_fall) begin
                    case (mode)
                        HSC_MODE_RUN:  nxt_state = HSC_ST_HALT_NOP;
                        HSC_MODE_STOP: nxt_state = HSC_ST_STOPPED;
                        default:       nxt_state = HSC_ST_GATED;
                    endcase
                end
            end
            HSC_ST_GATED: begin
                if (wake_req) begin
                    nxt_state = HSC_ST_HALT_NOP;
                end
            end
            HSC_ST_STOPPED: begin
                if (wake_req) begin
                    nxt_state = HSC_ST_WARMUP;
                end
            end
            HSC_ST_WARMUP: begin
                if (warm_ff == WARM_LAST) begin
                    nxt_state = HSC_ST_HALT_NOP;
                end
            end
            default: begin
                nxt_state = HSC_ST_RST_HOLD;
            end
        endcase
        // The reset pin overrides everything and never waits for the warm-up.
        if (rst_pin) begin
            nxt_state = HSC_ST_RST_HOLD;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_ff <= HSC_ST_RST_HOLD;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Remember which idle mode gated the clock, so a select change while idle cannot glitch it.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            gate_mode_ff <= HSC_MODE_RUN;
        end else if (t4_fall) begin
            gate_mode_ff <= mode;
        end
    end

    // Half-period divider; it idles at zero while the oscillator is off.
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !osc_on) begin
            half_cnt_ff <= '0;
        end else if (free_tick) begin
            half_cnt_ff <= '0;
        end else begin
            half_cnt_ff <= half_cnt_ff + `HSC_HALF_W'(1);
        end
    end

    // Phase 0 is the high half of a T-state, phase 1 the low half; gating freezes at low.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phase_ff <= 1'b0;
        end else if (half_tick) begin
            phase_ff <= !phase_ff;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            tstate_ff <= `HSC_T1;
        end else if ((state_ff == HSC_ST_RST_HOLD) || (state_ff == HSC_ST_DUMMY)) begin
            tstate_ff <= `HSC_T1;
        end else if (t_end) begin
            tstate_ff <= tstate_ff + `HSC_T_STEP;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i || (state_ff != HSC_ST_DUMMY)) begin
            dummy_ff <= `HSC_DUMMY_RST;
        end else if (t_end) begin
            dummy_ff <= dummy_ff + `HSC_DUMMY_W'(1);
        end
    end

    // Cleared in every state but warm-up, so each wake counts the full interval.
    always_ff @(posedge clk_i) begin
        if (!resetn_i || (state_ff != HSC_ST_WARMUP)) begin
            warm_ff <= `HSC_WARM_RST;
        end else begin
            warm_ff <= warm_ff + `HSC_WARM_W'(1);
        end
    end

    // Latch set wins over a clear arriving in the same cycle.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            nmi_prev_ff <= 1'b1;
            nmi_lat_ff  <= 1'b0;
        end else begin
            nmi_prev_ff <= pin_s.nmi_req_n;
            if (nmi_fall) begin
                nmi_lat_ff <= 1'b1;
            end else if (nmi_acc || nmi_taken_i || rst_pin) begin
                nmi_lat_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            halt_n_ff <= 1'b1;
        end else if (rst_pin || nmi_acc || int_acc) begin
            halt_n_ff <= 1'b1;
        end else if (t4_fall && halt_fetch) begin
            halt_n_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            int_ack_ff <= 1'b0;
            nmi_ack_ff <= 1'b0;
        end else begin
            int_ack_ff <= int_acc;
            nmi_ack_ff <= nmi_acc;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            phi_ff <= 1'b1;
        end else if (half_tick) begin
            phi_ff <= phase_ff;
        end
    end

    // Outside the core-only idle the pin follows the core clock, so both restart together.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            clk_out_ff <= 1'b1;
        end else if (run_clk) begin
            if (half_tick) begin
                clk_out_ff <= phase_ff;
            end
        end else if ((state_ff == HSC_ST_GATED) && (gate_mode_ff == HSC_MODE_GATED_CORE)) begin
            if (free_tick) begin
                clk_out_ff <= !clk_out_ff;
            end
        end else begin
            clk_out_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            osc_run_ff    <= 1'b1;
            fetch_zero_ff <= 1'b0;
        end else begin
            osc_run_ff    <= (nxt_state != HSC_ST_STOPPED);
            fetch_zero_ff <= (state_ff == HSC_ST_DUMMY) && (nxt_state == HSC_ST_RUN);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ref_ff <= `HSC_REF_RST;
        end else if (t_end && fetch_now && (tstate_ff == `HSC_T4)) begin
            ref_ff <= ref_ff + `HSC_REF_STEP;
        end
    end

    assign halt_n_o               = halt_n_ff;
    assign phi_o                  = phi_ff;
    assign phi_tick_o             = t_end;
    assign tstate_o               = tstate_ff;
    assign clk_out_o              = clk_out_ff;
    assign osc_run_o              = osc_run_ff;
    assign core_reset_o           = (state_ff == HSC_ST_RST_HOLD) || (state_ff == HSC_ST_DUMMY);
    assign fetch_zero_o           = fetch_zero_ff;
    assign int_ack_o              = int_ack_ff;
    assign nmi_ack_o              = nmi_ack_ff;
    assign opcode_fetch_cycle_n_o = !(fetch_now && !tstate_ff[1]);
    // The refresh address owns the bus in the second half of every fetch.
    assign refresh_addr_en_o      = fetch_now && tstate_ff[1];
    assign refresh_addr_o         = ref_ff;

endmodule : hsc_top
